/* File: hw/tws_regs.sv */
`include "tws_cfg.svh"
`default_nettype none

module tws_regs
  import tws_pkg::*;
#(
  parameter logic        FAST_CAPABLE = 1'b1,
  // arbitrary identification values
  parameter logic [11:0] VERSION_NUM  = 12'h001,
  parameter logic [3:0]  VARIANT_NUM  = 4'h0
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid_i,
  output var  logic        s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic [2:0]  s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid_i,
  output var  logic        s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // axi4-lite write response
  output var  logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output var  logic [1:0]  s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid_i,
  output var  logic        s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic [2:0]  s_axi_arprot_i,
  // axi4-lite read data
  output var  logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output var  logic [31:0] s_axi_rdata_o,
  output var  logic [1:0]  s_axi_rresp_o,
  // protocol engine status
  input  wire logic        slave_on_i,
  input  wire logic        tx_empty_i,
  input  wire logic        rx_avail_i,
  input  wire logic        xmit_mode_i,
  input  wire logic        addressed_i,
  input  wire logic        stop_seen_i,
  input  wire logic [31:0] event_i,
  // data drive timing
  input  wire logic        fast_mode_i,
  input  wire logic        clock_low_seen_i,
  output var  logic        data_drive_o,
  // pad controls
  output var  logic [1:0]  norm_filter_o,
  output var  logic [1:0]  norm_slew_o,
  output var  logic [2:0]  norm_pull_o,
  output var  logic [1:0]  fast_filter_o,
  output var  logic [1:0]  fast_slew_o,
  output var  logic [2:0]  fast_pull_o,
  // interrupt
  output var  logic        irq_o
);

  tws_state_s s;
  tws_state_s next_s;

  logic [31:0] live;
  logic [31:0] status;
  logic [31:0] lane;
  logic [31:0] wval;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  logic        wr_go;
  logic        done_set;

  // register word indices, sized to the decoded address bits
  localparam logic [5:0] IDX_STATUS   = 6'(`TWS_OFS_STATUS >> 2);
  localparam logic [5:0] IDX_IRQ_SET  = 6'(`TWS_OFS_IRQ_SET >> 2);
  localparam logic [5:0] IDX_IRQ_CLR  = 6'(`TWS_OFS_IRQ_CLR >> 2);
  localparam logic [5:0] IDX_IRQ_MASK = 6'(`TWS_OFS_IRQ_MASK >> 2);
  localparam logic [5:0] IDX_STAT_CLR = 6'(`TWS_OFS_STAT_CLR >> 2);
  localparam logic [5:0] IDX_CAPS     = 6'(`TWS_OFS_CAPS >> 2);
  localparam logic [5:0] IDX_REVISION = 6'(`TWS_OFS_REVISION >> 2);
  localparam logic [5:0] IDX_HOLD     = 6'(`TWS_OFS_HOLD >> 2);
  localparam logic [5:0] IDX_PAD_NORM = 6'(`TWS_OFS_PAD_NORM >> 2);
  localparam logic [5:0] IDX_PAD_FAST = 6'(`TWS_OFS_PAD_FAST >> 2);

  // level bits come straight from the engine, never stored
  always_comb begin
    live = 32'h0000_0000;
    live[`TWS_BIT_RX_AVAIL]  = rx_avail_i;
    live[`TWS_BIT_TX_EMPTY]  = tx_empty_i;
    live[`TWS_BIT_SLAVE_ON]  = slave_on_i;
    live[`TWS_BIT_XMIT_MODE] = xmit_mode_i;
  end

  assign status = live | s.sticky;

  // byte lanes of the pending write
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane[i*8 +: 8] = {8{s.wstb[i]}};
    end
  end

  assign wval = s.wdat & lane;

  // stop only completes a transfer we took part in
  assign done_set = stop_seen_i & addressed_i;

  always_comb begin
    unique case (s.aw_adr[7:2])
      IDX_STATUS,
      IDX_IRQ_SET,
      IDX_IRQ_CLR,
      IDX_IRQ_MASK,
      IDX_STAT_CLR,
      IDX_CAPS,
      IDX_REVISION,
      IDX_HOLD,
      IDX_PAD_NORM,
      IDX_PAD_FAST: wr_hit = 1'b1;
      default:                wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr_i[7:2])
      IDX_STATUS: begin
        rd_word = status;
      end
      IDX_IRQ_SET,
      IDX_IRQ_CLR,
      IDX_STAT_CLR: begin
        rd_word = 32'h0000_0000;
      end
      IDX_IRQ_MASK: begin
        rd_word = s.mask;
      end
      IDX_CAPS: begin
        rd_word = {31'h0000_0000, FAST_CAPABLE};
      end
      IDX_REVISION: begin
        rd_word = {12'h000, VARIANT_NUM, 4'h0, VERSION_NUM};
      end
      IDX_HOLD: begin
        rd_word = {8'h00, s.hold, 16'h0000};
      end
      IDX_PAD_NORM: begin
        rd_word = s.pad_norm;
      end
      IDX_PAD_FAST: begin
        rd_word = s.pad_fast;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // both halves of a write held and no response pending
  assign wr_go = s.aw_full & s.w_full & ~s.bvalid;

  always_comb begin
    next_s = s;

    // write address and data are taken in either order
    if (s_axi_awvalid_i && s.awrdy) begin
      next_s.aw_full = 1'b1;
      next_s.aw_adr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wrdy) begin
      next_s.w_full = 1'b1;
      next_s.wdat   = s_axi_wdata_i;
      next_s.wstb   = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end

    // hardware sets land after the clear, so a set wins
    if (wr_go && s.aw_adr[7:2] == IDX_STAT_CLR) begin
      next_s.sticky = s.sticky & ~(wval & `TWS_STICKY_MASK);
    end
    next_s.sticky = next_s.sticky | (event_i & `TWS_STICKY_MASK);
    if (done_set) begin
      next_s.sticky[`TWS_BIT_XFER_DONE] = 1'b1;
    end

    if (wr_go) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_hit ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
      unique case (s.aw_adr[7:2])
        IDX_IRQ_SET: begin
          next_s.mask = s.mask | (wval & `TWS_IRQ_MASK);
        end
        IDX_IRQ_CLR: begin
          next_s.mask = s.mask & ~wval;
        end
        IDX_HOLD: begin
          if (s.wstb[2]) begin
            next_s.hold = s.wdat[`TWS_HOLD_MSB:`TWS_HOLD_LSB];
          end
        end
        IDX_PAD_NORM: begin
          next_s.pad_norm = (s.pad_norm & ~lane) | (wval & `TWS_PAD_MASK);
        end
        IDX_PAD_FAST: begin
          next_s.pad_fast = (s.pad_fast & ~lane) | (wval & `TWS_PAD_MASK);
        end
        default: begin
        end
      endcase
    end

    // ready only while the holding slot is free
    next_s.awrdy = ~next_s.aw_full & ~next_s.bvalid;
    next_s.wrdy  = ~next_s.w_full & ~next_s.bvalid;

    // read: one outstanding, answered the edge after acceptance
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arrdy) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word;
      next_s.rresp  = rd_hit ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
    end
    next_s.arrdy = ~next_s.rvalid;

    // data drive delay after the clock line is seen low
    next_s.drive = 1'b0;
    if (clock_low_seen_i) begin
      if (fast_mode_i && s.hold != 8'h00) begin
        next_s.hold_busy = 1'b1;
        next_s.hold_cnt  = s.hold;
      end else begin
        next_s.hold_busy = 1'b0;
        next_s.drive     = 1'b1;
      end
    end else if (s.hold_busy) begin
      if (s.hold_cnt == 8'h01) begin
        next_s.hold_busy = 1'b0;
        next_s.drive     = 1'b1;
      end
      next_s.hold_cnt = s.hold_cnt - 8'h01;
    end

    // registered so the line is glitch free; built from next-state flags and mask, so it lags only the level inputs by one edge
    next_s.irq = |((live | next_s.sticky) & next_s.mask);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s          <= '0;
      s.mask     <= `TWS_MASK_RESET;
      s.hold     <= `TWS_HOLD_RESET;
      s.pad_norm <= `TWS_PAD_RESET;
      s.pad_fast <= `TWS_PAD_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_o = s.awrdy;
  assign s_axi_wready_o  = s.wrdy;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_arready_o = s.arrdy;
  assign s_axi_rvalid_o  = s.rvalid;
  assign s_axi_rdata_o   = s.rdata;
  assign s_axi_rresp_o   = s.rresp;
  assign data_drive_o    = s.drive;
  assign irq_o           = s.irq;

  // filter codes 0/1 normal and 0/2/3 fast are reserved; passed as written
  assign norm_filter_o = s.pad_norm[`TWS_FILT_MSB:`TWS_FILT_LSB];
  assign norm_slew_o   = s.pad_norm[`TWS_SLEW_MSB:`TWS_SLEW_LSB];
  assign norm_pull_o   = s.pad_norm[`TWS_PULL_MSB:`TWS_PULL_LSB];
  assign fast_filter_o = s.pad_fast[`TWS_FILT_MSB:`TWS_FILT_LSB];
  assign fast_slew_o   = s.pad_fast[`TWS_SLEW_MSB:`TWS_SLEW_LSB];
  assign fast_pull_o   = s.pad_fast[`TWS_PULL_MSB:`TWS_PULL_LSB];

  // prot is accepted and ignored
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot_i, s_axi_arprot_i};

endmodule : tws_regs

`default_nettype wire

/* File: hw/tws_cfg.svh */
`ifndef TWS_CFG_SVH
`define TWS_CFG_SVH

// register byte offsets
`define TWS_OFS_STATUS      8'h18
`define TWS_OFS_IRQ_SET     8'h1C
`define TWS_OFS_IRQ_CLR     8'h20
`define TWS_OFS_IRQ_MASK    8'h24
`define TWS_OFS_STAT_CLR    8'h28
`define TWS_OFS_CAPS        8'h2C
`define TWS_OFS_REVISION    8'h30
`define TWS_OFS_HOLD        8'h34
`define TWS_OFS_PAD_NORM    8'h38
`define TWS_OFS_PAD_FAST    8'h3C

// status bit positions
`define TWS_BIT_RX_AVAIL    0
`define TWS_BIT_TX_EMPTY    1
`define TWS_BIT_SLAVE_ON    2
`define TWS_BIT_XFER_DONE   3
`define TWS_BIT_XMIT_MODE   5

// sticky bits cleared by the status-clear register
`define TWS_STICKY_MASK     32'h00FB_71C8
// bits that may be enabled as interrupt sources
`define TWS_IRQ_MASK        32'h00FB_71CB
`define TWS_MASK_RESET      32'h0000_0000
`define TWS_HOLD_RESET      8'h00
`define TWS_PAD_RESET       32'h0000_0000

// field layouts
`define TWS_HOLD_LSB        16
`define TWS_HOLD_MSB        23
`define TWS_PAD_MASK        32'h3000_0307
`define TWS_FILT_MSB        29
`define TWS_FILT_LSB        28
`define TWS_SLEW_MSB        9
`define TWS_SLEW_LSB        8
`define TWS_PULL_MSB        2
`define TWS_PULL_LSB        0

// bus responses
`define TWS_RESP_OKAY       2'h0
`define TWS_RESP_SLVERR     2'h2

`endif

/* File: hw/tws_pkg.sv */
`default_nettype none

package tws_pkg;

  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_adr;
    logic [31:0] wdat;
    logic [3:0]  wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] sticky;
    logic [31:0] mask;
    logic [7:0]  hold;
    logic [31:0] pad_norm;
    logic [31:0] pad_fast;
    logic [7:0]  hold_cnt;
    logic        hold_busy;
    logic        drive;
    logic        irq;
  } tws_state_s;

endpackage : tws_pkg

`default_nettype wire

/* File: dv/tws_engine_model.sv */
`default_nettype none
module tws_engine_model (
  // clock
  input  wire logic        clock_i,
  // engine status toward the registers
  output var  logic [3:0]  level_o,
  output var  logic        addressed_o,
  output var  logic        stop_o,
  output var  logic        clock_low_o,
  output var  logic [31:0] event_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // level order: xmit, slave on, tx empty, rx avail
  initial {level_o, addressed_o, stop_o, clock_low_o, event_o} = '0;
  task automatic set_lvl(input logic [3:0] l, input logic a);
    @(posedge clock_i);
    level_o     <= l;
    addressed_o <= a;
  endtask : set_lvl
  // single-cycle strobes, as the engine raises them
  task automatic fire(input logic [31:0] ev, input logic stp, input logic cl);
    @(posedge clock_i);
    event_o     <= ev;
    stop_o      <= stp;
    clock_low_o <= cl;
    @(posedge clock_i);
    event_o     <= 32'h0;
    stop_o      <= 1'b0;
    clock_low_o <= 1'b0;
  endtask : fire
endmodule : tws_engine_model
`default_nettype wire

/* File: dv/tws_regs_monitor.sv */
`default_nettype none
module tws_regs_monitor (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        reset_i,
  // register bus
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  // engine and outputs
  input wire logic        rx_avail_i,
  input wire logic        tx_empty_i,
  input wire logic        addressed_i,
  input wire logic        stop_seen_i,
  input wire logic [31:0] event_i,
  input wire logic        fast_mode_i,
  input wire logic        clock_low_seen_i,
  input wire logic        data_drive_o,
  input wire logic [1:0]  norm_filter_o,
  input wire logic [1:0]  fast_filter_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // irq may trail its cause by one edge, so both lags pass
  wire logic cause = |event_i || (stop_seen_i && addressed_i) || rx_avail_i || tx_empty_i;
  wire logic lv_low = !rx_avail_i || !tx_empty_i;
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered");
  a_rd_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("read data dropped");
  a_wr_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_drive_slow: assert property (clock_low_seen_i && !fast_mode_i |=> data_drive_o)
    else $error("data drive late");
  a_pad_on_write: assert property (!$stable({norm_filter_o, fast_filter_o}) |-> $rose(s_axi_bvalid_o))
    else $error("pad field moved without write");
  a_irq_rise: assert property ($rose(irq_o) |->
    s_axi_bvalid_o || $past(s_axi_bvalid_o) || $past(cause) || $past(cause, 2)) else $error("irq rose unprompted");
  a_irq_fall: assert property ($fell(irq_o) |->
    s_axi_bvalid_o || $past(s_axi_bvalid_o) || $past(lv_low) || $past(lv_low, 2)) else $error("irq fell unprompted");
  a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> !irq_o && !data_drive_o && !s_axi_rvalid_o)
    else $error("outputs busy in reset");
  c_irq: cover property ($rose(irq_o));
  c_drive: cover property (data_drive_o);
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
endmodule : tws_regs_monitor
bind tws_regs tws_regs_monitor u_monitor (
  .clock_i, .reset_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .rx_avail_i, .tx_empty_i, .addressed_i,
  .stop_seen_i, .event_i, .fast_mode_i, .clock_low_seen_i, .data_drive_o, .norm_filter_o,
  .fast_filter_o, .irq_o
);
`default_nettype wire

/* File: dv/tb_i2c_slave_irq_and_timing_regs.sv */
`default_nettype none
module tb_i2c_slave_irq_and_timing_regs;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] rv;} tws_row_s;
  logic        clock_i = 1'b0, reset_i = 1'b1, fast_mode_i = 1'b0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, event_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, norm_filter_o, norm_slew_o, fast_filter_o, fast_slew_o;
  logic [2:0]  norm_pull_o, fast_pull_o;
  logic        data_drive_o, irq_o, addressed_i, stop_seen_i, clock_low_seen_i;
  logic [3:0]  lvl;
  logic [7:0]  zero_adr[4] = '{8'h24, 8'h34, 8'h38, 8'h3C};
  int          mismatches = 0, tests_run = 0, stall = 0, k;
  tws_row_s    rows[8] = '{
    '{8'h34, 32'hFFFF_FFFF, 8'h34, 32'h00FF_0000}, '{8'h38, 32'hFFFF_FFFF, 8'h38, 32'h3000_0307},
    '{8'h3C, 32'h1000_0201, 8'h3C, 32'h1000_0201}, '{8'h2C, 32'h0000_0000, 8'h2C, 32'h0000_0001},
    '{8'h30, 32'hFFFF_FFFF, 8'h30, 32'h0000_0001}, '{8'h1C, 32'h0000_000B, 8'h24, 32'h0000_000B},
    '{8'h20, 32'h0000_0000, 8'h24, 32'h0000_000B}, '{8'h20, 32'h0000_0003, 8'h1C, 32'h0000_0000}};
  always #25 clock_i = ~clock_i;
  tws_regs DUT (
    .clock_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i, .s_axi_awprot_i(3'h0),
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i,
    .s_axi_arprot_i(3'h0), .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o,
    .slave_on_i(lvl[2]), .tx_empty_i(lvl[1]), .rx_avail_i(lvl[0]), .xmit_mode_i(lvl[3]),
    .addressed_i, .stop_seen_i, .event_i, .fast_mode_i, .clock_low_seen_i, .data_drive_o,
    .norm_filter_o, .norm_slew_o, .norm_pull_o, .fast_filter_o, .fast_slew_o, .fast_pull_o, .irq_o);
  tws_engine_model eng (.clock_i, .level_o(lvl), .addressed_o(addressed_i), .stop_o(stop_seen_i),
    .clock_low_o(clock_low_seen_i), .event_o(event_i));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    tests_run++;
    if (seen !== ex) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= (stall == 0);
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      if (n == stall) s_axi_bready_i <= 1'b1;
    end while ((s_axi_bvalid_o && s_axi_bready_i) !== 1'b1 && n < 20);
    s_axi_bready_i <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp_o}, {30'h0, er});
    chk("write wait", {31'h0, n < 20}, 32'h1);
    if (n >= 20) wrap_up();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= (stall == 0);
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      if (n == stall) s_axi_rready_i <= 1'b1;
    end while ((s_axi_rvalid_o && s_axi_rready_i) !== 1'b1 && n < 20);
    s_axi_rready_i <= 1'b0;
    chk($sformatf("rdata %h", a), s_axi_rdata_o, ex);
    chk("rresp", {30'h0, s_axi_rresp_o}, {30'h0, er});
    chk("read wait", {31'h0, n < 20}, 32'h1);
    if (n >= 20) wrap_up();
  endtask : rd
  task automatic irq_is(input logic ex);
    repeat (2) @(posedge clock_i);
    chk("irq", {31'h0, irq_o}, {31'h0, ex});
  endtask : irq_is
  initial begin
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    eng.set_lvl(4'h6, 1'b0);
    foreach (zero_adr[i]) rd(zero_adr[i], 32'h0, 2'h0);
    rd(8'h18, 32'h0000_0006, 2'h0);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd, 2'h0);
      rd(rows[i].ra, rows[i].rv, 2'h0);
    end
    chk("pads", {18'h0, norm_filter_o, norm_slew_o, norm_pull_o, fast_filter_o, fast_slew_o, fast_pull_o},
      {18'h0, 7'h7F, 7'h31});
    // unmapped access, with a slow master holding off the answers
    stall = 3;
    wr(8'h40, 32'hFFFF_FFFF, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    stall = 0;
    rd(8'h24, 32'h0000_0008, 2'h0);
    eng.fire(32'h0, 1'b1, 1'b0);
    irq_is(1'b0);
    eng.set_lvl(4'h6, 1'b1);
    eng.fire(32'h0, 1'b1, 1'b0);
    irq_is(1'b1);
    rd(8'h18, 32'h0000_000E, 2'h0);
    wr(8'h20, 32'h0000_0008, 2'h0);
    irq_is(1'b0);
    wr(8'h1C, 32'h0000_0008, 2'h0);
    irq_is(1'b1);
    wr(8'h28, 32'h0000_0000, 2'h0);
    irq_is(1'b1);
    wr(8'h28, 32'hFFFF_FFFF, 2'h0);
    irq_is(1'b0);
    eng.fire(32'hFFFF_FFFF, 1'b0, 1'b0);
    eng.set_lvl(4'hF, 1'b0);
    wr(8'h28, 32'h0000_0008, 2'h0);
    rd(8'h18, 32'h00FB_71E7, 2'h0);
    wr(8'h1C, 32'h0000_0001, 2'h0);
    wr(8'h28, 32'hFFFF_FFFF, 2'h0);
    irq_is(1'b1);
    eng.set_lvl(4'hE, 1'b0);
    irq_is(1'b0);
    wr(8'h34, 32'h0003_0000, 2'h0);
    for (int f = 0; f < 2; f++) begin
      fast_mode_i <= f[0];
      eng.fire(32'h0, 1'b0, 1'b1);
      k = 0;
      do begin
        @(posedge clock_i);
        k++;
      end while (data_drive_o !== 1'b1 && k < 10);
      chk("drive delay", k, f ? 32'h4 : 32'h1);
      @(posedge clock_i);
      chk("drive pulse", {31'h0, data_drive_o}, 32'h0);
    end
    // mid-run reset: mask, timing, pads and irq back to rest
    wr(8'h1C, 32'h0000_0002, 2'h0);
    irq_is(1'b1);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    chk("irq in reset", {31'h0, irq_o}, 32'h0);
    foreach (zero_adr[i]) rd(zero_adr[i], 32'h0, 2'h0);
    wrap_up();
  end
endmodule : tb_i2c_slave_irq_and_timing_regs
`default_nettype wire
